// ---- src/temp_serial_slave.v ----
// Purpose: two-wire slave front end holding the temperature result
// Assumes: scl_in, sda_in and straps are asynchronous pins
// Notes: bus is oversampled by clk, so SCL must stay well below clk/8
`default_nettype none
`include "tsense_defs.vh"

module temp_serial_slave #(
	parameter TRI_LEVEL = 1,
	parameter TIMEOUT_CYC = TRI_LEVEL ? `TOUT_TRI_CYC : `TOUT_BIN_CYC
) (
	input wire clk,
	input wire sys_rst,
	input wire clk_en,
	input wire scl_in,
	output reg scl_out,
	output reg scl_oe_n,
	input wire sda_in,
	output reg sda_out,
	output reg sda_oe_n,
	input wire addr_strap_bit0,
	input wire addr_strap_bit1,
	input wire addr_strap_bit2,
	input wire [2:0] strap_float,
	input wire conv_valid,
	input wire [15:0] conv_temp,
	input wire [1:0] resolution,
	output reg [15:0] temp_result_reg,
	output reg hs_mode_reg,
	output reg addressed_reg,
	output reg timeout_reg
);

	reg scl_s1, scl_s2, scl_d;
	reg sda_s1, sda_s2, sda_d;
	reg [2:0] strap_s1, strap_s2;
	reg [2:0] float_s1, float_s2;
	reg [2:0] state_reg;
	reg [3:0] bit_cnt_reg;
	reg [7:0] shift_reg;
	reg rw_reg, gc_reg, ptr_done_reg, ack_phase_reg, byte_sel_reg;
	reg [1:0] pointer_reg;
	reg busy_reg, rst_latch_reg, gc_latch_reg;
	reg [31:0] tout_cnt_reg;
	wire [6:0] own_addr;
	wire scl_rise, scl_fall, start_ev, stop_ev;
	wire [7:0] rx_byte;
	wire strap_latch;
	reg [11:0] sat_temp, res_mask;
	wire [15:0] read_word;
	wire [7:0] tx_byte;

	// only edges of the second stage are looked at
	assign scl_rise = scl_s2 & ~scl_d;
	assign scl_fall = ~scl_s2 & scl_d;
	assign start_ev = scl_s2 & scl_d & sda_d & ~sda_s2;
	assign stop_ev = scl_s2 & scl_d & ~sda_d & sda_s2;
	assign rx_byte = {shift_reg[6:0], sda_s2};
	// latch after reset, at start, on general-call relatch or reset
	assign strap_latch = rst_latch_reg | start_ev | gc_latch_reg;
	// upper twelve bits, pointer selects word
	assign read_word = (pointer_reg == `PTR_TEMP) ? temp_result_reg : `UNMAPPED_READ;
	assign tx_byte = byte_sel_reg ? read_word[7:0] : read_word[15:8];

	strap_resolver #(
		.TRI_LEVEL(TRI_LEVEL)
	) u_strap (
		.clk(clk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.latch(strap_latch),
		.level(strap_s2),
		.is_float(float_s2),
		.addr_reg(own_addr)
	);

	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			scl_s1 <= 1'b1;
			scl_s2 <= 1'b1;
			scl_d <= 1'b1;
			sda_s1 <= 1'b1;
			sda_s2 <= 1'b1;
			sda_d <= 1'b1;
			strap_s1 <= 3'h0;
			strap_s2 <= 3'h0;
			float_s1 <= 3'h0;
			float_s2 <= 3'h0;
		end else if (clk_en) begin
			scl_s1 <= scl_in;
			scl_s2 <= scl_s1;
			scl_d <= scl_s2;
			sda_s1 <= sda_in;
			sda_s2 <= sda_s1;
			sda_d <= sda_s2;
			strap_s1 <= {addr_strap_bit2, addr_strap_bit1, addr_strap_bit0};
			strap_s2 <= strap_s1;
			float_s1 <= strap_float;
			float_s2 <= float_s1;
		end
	end

	always @* begin
		if (!conv_temp[15] && (conv_temp[14:11] != 4'h0)) begin
			sat_temp = `TEMP_MAX;
		end else if (conv_temp[15] && (conv_temp[14:11] != 4'hF)) begin
			sat_temp = `TEMP_MIN;
		end else begin
			sat_temp = conv_temp[11:0];
		end
		case (resolution)
			2'h0: res_mask = 12'hFF8;
			2'h1: res_mask = 12'hFFC;
			2'h2: res_mask = 12'hFFE;
			default: res_mask = 12'hFFF;
		endcase
	end

	// converter loads the result, general-call reset clears it
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			temp_result_reg <= `TEMP_RESET;
		end else if (clk_en) begin
			if (gc_latch_reg && shift_reg == `GC_RESET) begin
				temp_result_reg <= `TEMP_RESET;
			end else if (conv_valid) begin
				temp_result_reg <= {sat_temp & res_mask, 4'h0};
			end
		end
	end

	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg <= `ST_IDLE;
			bit_cnt_reg <= 4'h0;
			shift_reg <= 8'h00;
			rw_reg <= 1'b0;
			gc_reg <= 1'b0;
			ptr_done_reg <= 1'b0;
			ack_phase_reg <= 1'b0;
			byte_sel_reg <= 1'b0;
			pointer_reg <= `PTR_RESET;
			busy_reg <= 1'b0;
			rst_latch_reg <= 1'b1;
			gc_latch_reg <= 1'b0;
			tout_cnt_reg <= 32'h0;
			hs_mode_reg <= 1'b0;
			addressed_reg <= 1'b0;
			timeout_reg <= 1'b0;
			sda_out <= 1'b0;
			sda_oe_n <= 1'b1;
			scl_out <= 1'b0;
			scl_oe_n <= 1'b1;
		end else if (clk_en) begin
			rst_latch_reg <= 1'b0;
			gc_latch_reg <= 1'b0;
			timeout_reg <= 1'b0;
			// never stretches the clock, sda only pulled low
			scl_oe_n <= 1'b1;
			sda_out <= 1'b0;
			// count while a line sits low inside a frame
			if (busy_reg && (!scl_s2 || !sda_s2)) begin
				tout_cnt_reg <= tout_cnt_reg + 32'h1;
			end else begin
				tout_cnt_reg <= 32'h0;
			end
			if (busy_reg && tout_cnt_reg >= TIMEOUT_CYC - 1) begin
				// drop everything and wait for START
				state_reg <= `ST_IDLE;
				busy_reg <= 1'b0;
				sda_oe_n <= 1'b1;
				hs_mode_reg <= 1'b0;
				addressed_reg <= 1'b0;
				timeout_reg <= 1'b1;
				tout_cnt_reg <= 32'h0;
			end else if (start_ev) begin
				state_reg <= `ST_ADDR;
				bit_cnt_reg <= 4'h0;
				busy_reg <= 1'b1;
				sda_oe_n <= 1'b1;
				addressed_reg <= 1'b0;
			end else if (stop_ev) begin
				state_reg <= `ST_IDLE;
				busy_reg <= 1'b0;
				sda_oe_n <= 1'b1;
				hs_mode_reg <= 1'b0;
				addressed_reg <= 1'b0;
			end else begin
				case (state_reg)
					`ST_ADDR: begin
						if (scl_rise) begin
							shift_reg <= rx_byte;
							bit_cnt_reg <= bit_cnt_reg + 4'h1;
							if (bit_cnt_reg == 4'h7) begin
								rw_reg <= rx_byte[0];
								gc_reg <= 1'b0;
								ptr_done_reg <= 1'b0;
								byte_sel_reg <= 1'b0;
								ack_phase_reg <= 1'b0;
								if (rx_byte[7:3] == `HS_CODE_HI) begin
									hs_mode_reg <= 1'b1;
									state_reg <= `ST_IDLE;
								end else if (rx_byte[7:1] == own_addr) begin
									state_reg <= `ST_ACK;
									addressed_reg <= 1'b1;
								end else if (rx_byte[7:1] == `GCALL_ADDR && !rx_byte[0]) begin
									state_reg <= `ST_ACK;
									gc_reg <= 1'b1;
									addressed_reg <= 1'b1;
								end else begin
									state_reg <= `ST_IDLE;
								end
							end
						end
					end
					`ST_RX: begin
						if (scl_rise) begin
							shift_reg <= rx_byte;
							bit_cnt_reg <= bit_cnt_reg + 4'h1;
							if (bit_cnt_reg == 4'h7) begin
								state_reg <= `ST_ACK;
								ack_phase_reg <= 1'b0;
								if (gc_reg) begin
									if (rx_byte == `GC_RELATCH || rx_byte == `GC_RESET) begin
										gc_latch_reg <= 1'b1;
									end
									if (rx_byte == `GC_RESET) begin
										pointer_reg <= `PTR_RESET;
									end
								end else if (!ptr_done_reg) begin
									// first write byte is the pointer
									pointer_reg <= rx_byte[1:0];
									ptr_done_reg <= 1'b1;
								end
							end
						end
					end
					`ST_ACK: begin
						if (scl_fall) begin
							if (!ack_phase_reg) begin
								// hold SDA low over the ninth pulse
								sda_oe_n <= 1'b0;
								ack_phase_reg <= 1'b1;
							end else if (rw_reg) begin
								// first data bit out at once
								state_reg <= `ST_TX;
								shift_reg <= tx_byte;
								sda_oe_n <= tx_byte[7];
								bit_cnt_reg <= 4'h0;
							end else begin
								state_reg <= `ST_RX;
								sda_oe_n <= 1'b1;
								bit_cnt_reg <= 4'h0;
							end
						end
					end
					`ST_TX: begin
						if (scl_fall) begin
							bit_cnt_reg <= bit_cnt_reg + 4'h1;
							if (bit_cnt_reg == 4'h7) begin
								sda_oe_n <= 1'b1;
								state_reg <= `ST_MACK;
								byte_sel_reg <= ~byte_sel_reg;
							end else begin
								shift_reg <= {shift_reg[6:0], 1'b0};
								sda_oe_n <= shift_reg[6];
							end
						end
					end
					`ST_MACK: begin
						if (scl_rise && sda_s2) begin
							// not-acknowledge ends the read
							state_reg <= `ST_IDLE;
						end else if (scl_fall) begin
							state_reg <= `ST_TX;
							shift_reg <= tx_byte;
							sda_oe_n <= tx_byte[7];
							bit_cnt_reg <= 4'h0;
						end
					end
					default: begin
						sda_oe_n <= 1'b1;
					end
				endcase
			end
		end
	end

endmodule // temp_serial_slave
`default_nettype wire

// ---- src/tsense_defs.vh ----
// Purpose: shared constants of the temperature sensor serial slave
// Assumes: included by bare name from the design files
// Notes: times in microseconds, rate in MHz
`ifndef TSENSE_DEFS_VH
`define TSENSE_DEFS_VH

`define CLK_MHZ 25
`define TOUT_TRI_US 54000
`define TOUT_BIN_US 25000
`define TOUT_TRI_CYC (`TOUT_TRI_US * `CLK_MHZ)
`define TOUT_BIN_CYC (`TOUT_BIN_US * `CLK_MHZ)

`define BIN_ADDR_HI 4'h9
`define GCALL_ADDR 7'h00
`define HS_CODE_HI 5'h01
`define GC_RELATCH 8'h04
`define GC_RESET 8'h06

`define PTR_TEMP 2'h0
`define PTR_RESET 2'h0
`define TEMP_RESET 16'h0000
`define TEMP_MAX 12'h7FF
`define TEMP_MIN 12'h800
`define UNMAPPED_READ 16'h0000

`define ST_IDLE 3'h0
`define ST_ADDR 3'h1
`define ST_RX 3'h2
`define ST_ACK 3'h3
`define ST_TX 3'h4
`define ST_MACK 3'h5

`endif

// ---- src/strap_resolver.v ----
// Purpose: turns the three address straps into the seven-bit slave address
// Assumes: strap levels and float flags already synchronised to clk
// Notes: address holds between latch pulses so detection can sleep
`default_nettype none
`include "tsense_defs.vh"

module strap_resolver #(
	parameter TRI_LEVEL = 1
) (
	input wire clk,
	input wire sys_rst,
	input wire clk_en,
	input wire latch,
	input wire [2:0] level,
	input wire [2:0] is_float,
	output reg [6:0] addr_reg
);

	wire [2:0] flt;
	wire [2:0] lvl;
	reg [6:0] addr_next;

	assign flt = TRI_LEVEL ? is_float : 3'h0;
	assign lvl = level & ~flt;

	always @* begin
		addr_next = {`BIN_ADDR_HI, lvl};
		case ({flt, lvl})
			6'h20: addr_next = 7'h70;
			6'h28: addr_next = 7'h71;
			6'h21: addr_next = 7'h72;
			6'h22: addr_next = 7'h73;
			6'h2A: addr_next = 7'h74;
			6'h23: addr_next = 7'h75;
			6'h30: addr_next = 7'h76;
			6'h31: addr_next = 7'h77;
			6'h10: addr_next = 7'h28;
			6'h11: addr_next = 7'h29;
			6'h14: addr_next = 7'h2A;
			6'h15: addr_next = 7'h2B;
			6'h08: addr_next = 7'h2C;
			6'h0A: addr_next = 7'h2D;
			6'h0C: addr_next = 7'h2E;
			6'h0E: addr_next = 7'h2F;
			6'h18: addr_next = 7'h35;
			6'h1C: addr_next = 7'h36;
			6'h38: addr_next = 7'h37;
			default: addr_next = {`BIN_ADDR_HI, lvl};
		endcase
	end

	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			addr_reg <= 7'h48;
		end else if (clk_en && latch) begin
			addr_reg <= addr_next;
		end
	end

endmodule // strap_resolver
`default_nettype wire

// ---- tb/temp_serial_slave_properties.sv ----
// Purpose: port-level properties of the sensor serial slave
// Assumes: bound to every temp_serial_slave instance
// Notes: pin-side low counter runs ahead of the block's own count
`default_nettype none
module temp_serial_slave_properties #(
	parameter int TRI_LEVEL = 1,
	parameter int TIMEOUT_CYC = 200
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic scl_in,
	input wire logic scl_out,
	input wire logic scl_oe_n,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe_n,
	input wire logic conv_valid,
	input wire logic [15:0] conv_temp,
	input wire logic [1:0] resolution,
	input wire logic [15:0] temp_result_reg,
	input wire logic hs_mode_reg,
	input wire logic addressed_reg,
	input wire logic timeout_reg
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [11:0] conv_q;
	logic [2:0] mask_q;
	int low_cnt;
	always @(posedge clk) begin
		conv_q <= conv_temp[11:0];
		mask_q <= 3'h7 >> resolution;
	end
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			low_cnt <= 0;
		end else if (scl_in && sda_in) begin
			low_cnt <= 0;
		end else begin
			low_cnt <= low_cnt + 1;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	pins_open_drain_a: assert property (scl_oe_n && !scl_out && !sda_out)
		else $error("pin driven high");
	low_nibble_zero_a: assert property (temp_result_reg[3:0] == 4'h0)
		else $error("low bits set");
	result_load_a: assert property (clk_en && conv_valid && resolution == 2'h3 &&
		(conv_temp[15:11] == 5'h00 || conv_temp[15:11] == 5'h1F)
		|=> temp_result_reg == {conv_q, 4'h0}) else $error("result load");
	result_saturate_a: assert property (clk_en && conv_valid && resolution == 2'h3 &&
		!conv_temp[15] &&
		conv_temp[14:11] != 4'h0 |=> temp_result_reg == 16'h7FF0) else $error("no saturation");
	res_mask_a: assert property (clk_en && conv_valid
		|=> (temp_result_reg[6:4] & mask_q) == 3'h0) else $error("resolution mask");
	result_held_a: assert property (!$stable(temp_result_reg)
		|-> $past(conv_valid) || $past(addressed_reg)) else $error("result changed");
	ack_when_matched_a: assert property ($fell(sda_oe_n) |-> addressed_reg)
		else $error("drive unaddressed");
	hs_exit_stop_a: assert property (scl_in && $rose(sda_in) |-> ##[1:6] !hs_mode_reg)
		else $error("hs mode stuck");
	ctrl_clears_match_a: assert property (scl_in && $past(scl_in) && sda_oe_n &&
		$past(sda_oe_n) && $changed(sda_in) |-> ##[1:6] !addressed_reg) else $error("match kept");
	timeout_bound_a: assert property (timeout_reg |-> low_cnt >= TIMEOUT_CYC)
		else $error("timeout early");
	timeout_release_a: assert property (timeout_reg
		|-> ##[0:2] (sda_oe_n && !addressed_reg && !hs_mode_reg)) else $error("no release");
	cover property (timeout_reg);
	cover property ($rose(hs_mode_reg));
	cover property ($fell(sda_oe_n));
endmodule // temp_serial_slave_properties
bind temp_serial_slave temp_serial_slave_properties #(
	.TRI_LEVEL(TRI_LEVEL),
	.TIMEOUT_CYC(TIMEOUT_CYC)
) temp_serial_slave_properties_inst (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
	.scl_in(scl_in), .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda_in),
	.sda_out(sda_out), .sda_oe_n(sda_oe_n), .conv_valid(conv_valid),
	.conv_temp(conv_temp), .resolution(resolution), .temp_result_reg(temp_result_reg),
	.hs_mode_reg(hs_mode_reg), .addressed_reg(addressed_reg), .timeout_reg(timeout_reg));
`default_nettype wire

// ---- tb/host_m.sv ----
// Purpose: two-wire bus master model
// Assumes: sda_in is the wired level with pull-up
// Notes: 320 ns bit, data moves mid low phase
`default_nettype none
module host_m (
	input wire logic clk,
	input wire logic sda_in,
	output var logic scl,
	output var logic sda
);
	timeunit 1ns;
	timeprecision 1ps;
	initial scl = 1'b1;
	initial sda = 1'b1;
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic bit_x(input logic b, output logic r);
		wt(2);
		sda <= b;
		wt(2);
		scl <= 1'b1;
		wt(4);
		r = sda_in;
		scl <= 1'b0;
	endtask
	task automatic start();
		wt(2);
		sda <= 1'b1;
		wt(2);
		scl <= 1'b1;
		wt(4);
		sda <= 1'b0;
		wt(4);
		scl <= 1'b0;
	endtask
	task automatic stop();
		wt(2);
		sda <= 1'b0;
		wt(2);
		scl <= 1'b1;
		wt(4);
		sda <= 1'b1;
		wt(4);
	endtask
	task automatic wr_byte(input logic [7:0] b, output logic k);
		logic r;
		for (int i = 7; i >= 0; i--) bit_x(b[i], r);
		bit_x(1'b1, r);
		k = ~r;
	endtask
	task automatic rd_byte(input logic nack, output logic [7:0] d);
		logic r;
		for (int i = 0; i < 8; i++) begin
			bit_x(1'b1, r);
			d = {d[6:0], r};
		end
		bit_x(nack, r);
	endtask
endmodule // host_m
`default_nettype wire

// ---- tb/temp_serial_slave_bench.sv ----
// Purpose: self-checking bench of the sensor serial slave
// Assumes: host_m drives the two-wire lines
// Notes: short timeout keeps the stuck-bus case brief
`default_nettype none
module temp_serial_slave_bench;
	timeunit 1ns;
	timeprecision 1ps;
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin num_errors++; \
$display("MISMATCH %s exp %h got %h", n, e, s); end end
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic clk_en = 1'b1;
	logic conv_valid = 1'b0;
	logic [15:0] conv_temp = 16'h0000;
	logic [1:0] resolution = 2'h3;
	logic [2:0] strap = 3'h0;
	logic [2:0] strap_float = 3'h0;
	logic scl, sda, scl_out, scl_oe_n, sda_out, sda_oe_n, hs_mode_reg, addressed_reg;
	logic timeout_reg, a;
	logic [15:0] temp_result_reg, d;
	int num_errors = 0;
	int total_checks = 0;
	int cyc = 0;
	wire sda_line = sda & sda_oe_n;
	wire scl_line = scl & scl_oe_n;
	initial forever #20 clk = ~clk;
	temp_serial_slave #(.TRI_LEVEL(1), .TIMEOUT_CYC(400)) temp_serial_slave_inst (.clk(clk),
		.sys_rst(sys_rst), .clk_en(clk_en), .scl_in(scl_line), .scl_out(scl_out),
		.scl_oe_n(scl_oe_n), .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
		.addr_strap_bit0(strap[0]), .addr_strap_bit1(strap[1]), .addr_strap_bit2(strap[2]),
		.strap_float(strap_float), .conv_valid(conv_valid), .conv_temp(conv_temp),
		.resolution(resolution), .temp_result_reg(temp_result_reg),
		.hs_mode_reg(hs_mode_reg), .addressed_reg(addressed_reg), .timeout_reg(timeout_reg));
	host_m host_m_inst (.clk(clk), .sda_in(sda_line), .scl(scl), .sda(sda));
	task automatic complete_run();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic conv(input logic [15:0] t, input logic [1:0] r, input logic [15:0] e);
		@(posedge clk);
		conv_valid <= 1'b1;
		conv_temp <= t;
		resolution <= r;
		@(posedge clk);
		conv_valid <= 1'b0;
		@(posedge clk);
		`CHK("result", e, temp_result_reg)
	endtask
	task automatic rd(input logic [6:0] ad, output logic [15:0] w, output logic k);
		w = 16'hFFFF;
		host_m_inst.start();
		host_m_inst.wr_byte({ad, 1'b1}, k);
		if (k) begin
			host_m_inst.rd_byte(1'b0, w[15:8]);
			host_m_inst.rd_byte(1'b1, w[7:0]);
		end
		host_m_inst.stop();
	endtask
	task automatic wr(input logic [6:0] ad, input logic [7:0] b, input int n, output logic k);
		logic r;
		host_m_inst.start();
		host_m_inst.wr_byte({ad, 1'b0}, k);
		for (int i = 0; i < n; i++) begin
			host_m_inst.wr_byte(b, r);
			k = k & r;
		end
		host_m_inst.stop();
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			num_errors++;
			complete_run();
		end
	end
	initial begin
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (8) @(posedge clk);
		`CHK("idle sda", 1'b1, sda_oe_n)
		rd(7'h48, d, a);
		`CHK("boot read", 16'h0000, d)
		conv(16'h0190, 2'h3, 16'h1900);
		conv(16'hFFFC, 2'h1, 16'hFFC0);
		conv(16'hFE70, 2'h2, 16'hE700);
		conv(16'h0004, 2'h0, 16'h0000);
		conv(16'hFC94, 2'h0, 16'hC900);
		conv(16'h0800, 2'h3, 16'h7FF0);
		conv(16'h0640, 2'h3, 16'h6400);
		@(posedge clk);
		clk_en <= 1'b0;
		conv_valid <= 1'b1;
		conv_temp <= 16'h0320;
		@(posedge clk);
		conv_valid <= 1'b0;
		@(posedge clk);
		clk_en <= 1'b1;
		@(posedge clk);
		`CHK("frozen", 16'h6400, temp_result_reg)
		rd(7'h48, d, a);
		`CHK("bus word", 16'h6400, d)
		wr(7'h48, 8'h00, 3, a);
		`CHK("write acked", 1'b1, a)
		`CHK("read only", 16'h6400, temp_result_reg)
		wr(7'h48, 8'h01, 1, a);
		rd(7'h48, d, a);
		`CHK("pointer 1", 16'h0000, d)
		wr(7'h48, 8'h00, 1, a);
		@(posedge clk);
		strap <= 3'h2;
		rd(7'h4A, d, a);
		`CHK("strap addr", 16'h6400, d)
		rd(7'h48, d, a);
		`CHK("old addr", 1'b0, a)
		@(posedge clk);
		strap_float <= 3'h7;
		rd(7'h37, d, a);
		`CHK("all float", 1'b1, a)
		@(posedge clk);
		strap <= 3'h0;
		strap_float <= 3'h4;
		rd(7'h70, d, a);
		`CHK("float top", 1'b1, a)
		host_m_inst.start();
		host_m_inst.wr_byte(8'h0B, a);
		`CHK("code nack", 1'b0, a)
		`CHK("hs on", 1'b1, hs_mode_reg)
		rd(7'h70, d, a);
		`CHK("hs read", 16'h6400, d)
		repeat (4) @(posedge clk);
		`CHK("hs off", 1'b0, hs_mode_reg)
		wr(7'h00, 8'h04, 1, a);
		`CHK("gc ack", 1'b1, a)
		`CHK("gc keep", 16'h6400, temp_result_reg)
		wr(7'h00, 8'h06, 1, a);
		`CHK("gc clear", 16'h0000, temp_result_reg)
		host_m_inst.start();
		host_m_inst.wr_byte(8'hE0, a);
		for (int i = 0; i < 600 && timeout_reg !== 1'b1; i++) @(posedge clk);
		`CHK("timeout", 1'b1, timeout_reg)
		repeat (3) @(posedge clk);
		`CHK("released", 1'b1, sda_oe_n)
		host_m_inst.stop();
		rd(7'h70, d, a);
		`CHK("after timeout", 1'b1, a)
		complete_run();
	end
endmodule // temp_serial_slave_bench
`default_nettype wire
